/* ssp_pkg.sv */
`default_nettype none
package ssp_pkg;

    localparam int SSP_DATA_W = 16;
    localparam int SSP_FIFO_DEPTH = 8;

    localparam logic [7:0] SSP_ADDR_CTRL = 8'h00;
    localparam logic [7:0] SSP_ADDR_PRESCALE = 8'h04;
    localparam logic [7:0] SSP_ADDR_RATE = 8'h08;
    localparam logic [7:0] SSP_ADDR_DATA = 8'h0C;
    localparam logic [7:0] SSP_ADDR_STATUS = 8'h10;

    localparam int SSP_CTRL_SIZE_LSB = 0;
    localparam int SSP_CTRL_FMT_LSB = 4;
    localparam int SSP_CTRL_ENABLE = 6;
    localparam int SSP_CTRL_SLAVE = 7;
    localparam int SSP_CTRL_OUT_DIS = 8;
    localparam int SSP_STAT_OVERRUN = 5;

    localparam logic [8:0] SSP_CTRL_RST = 9'h007;
    localparam logic [7:0] SSP_PRESCALE_RST = 8'h02;
    localparam logic [7:0] SSP_RATE_RST = 8'h00;

    localparam logic [3:0] SSP_SIZE_M1_MIN = 4'h3;
    localparam logic [4:0] SSP_CMD_BITS = 5'h08;

    typedef enum logic [1:0] {
        SSP_FMT_SPI = 2'b00,
        SSP_FMT_PULSE = 2'b01,
        SSP_FMT_CMD = 2'b10,
        SSP_FMT_SPARE = 2'b11
    } ssp_format_type;

    typedef enum logic [1:0] {
        SSP_IDLE = 2'b00,
        SSP_LEAD = 2'b01,
        SSP_TRAIL = 2'b10,
        SSP_GAP = 2'b11
    } ssp_state_type;

endpackage
`default_nettype wire

/* ssp_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module ssp_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;

    wire empty = (wr_ptr == rd_ptr);
    wire full = (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]) && (wr_ptr[AW] != rd_ptr[AW]);
    wire push = in_valid && !full;
    wire pop = out_ready && !empty;
    wire [AW:0] next_rd_ptr = rd_ptr + {{AW{1'b0}}, pop};
    wire bypass = push && (wr_ptr[AW-1:0] == next_rd_ptr[AW-1:0]);

    assign in_ready = !full;
    assign out_valid = !empty;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            wr_ptr <= wr_ptr + {{AW{1'b0}}, push};
            rd_ptr <= next_rd_ptr;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    // The head word is kept in a register so that it is valid one cycle after any change.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            out_data <= '0;
        end else begin
            out_data <= bypass ? in_data : mem[next_rd_ptr[AW-1:0]];
        end
    end
endmodule
`default_nettype wire

/* ssp_top.sv */
`timescale 1ns/1ps
`default_nettype none
module ssp_top
    import ssp_pkg::*;
#(
    parameter int FIFO_DEPTH = SSP_FIFO_DEPTH
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic [7:0] bus_addr,
    input wire logic [15:0] bus_wdata,
    input wire logic bus_write,
    input wire logic bus_read,
    output logic [15:0] bus_rdata,
    input wire logic sclk_in,
    output logic sclk_out,
    output logic sclk_oe,
    input wire logic fss_in,
    output logic fss_out,
    output logic fss_oe,
    input wire logic rxd_in,
    output logic txd_out,
    output logic txd_oe
);
    logic [8:0] ctrl;
    logic [7:0] prescale;
    logic [7:0] rate;
    logic overrun;
    logic [15:0] tx_sh;
    logic [15:0] rx_sh;
    logic [4:0] slot;
    logic rx_push;
    logic [15:0] rx_word;
    logic [6:0] pre_cnt;
    logic [7:0] rate_cnt;
    logic sclk_m1, sclk_m2, sclk_d;
    logic fss_m1, fss_m2, fss_d;
    logic rxd_m1, rxd_m2;
    ssp_state_type state;

    // Configuration fields.
    wire [3:0] size_raw = ctrl[SSP_CTRL_SIZE_LSB +: 4];
    wire [3:0] size_m1 = (size_raw < SSP_SIZE_M1_MIN) ? SSP_SIZE_M1_MIN : size_raw;
    wire [4:0] size = {1'b0, size_m1} + 5'h01;
    wire ssp_format_type fmt = ssp_format_type'(ctrl[SSP_CTRL_FMT_LSB +: 2]);
    wire is_pulse = (fmt == SSP_FMT_PULSE);
    wire is_cmd = (fmt == SSP_FMT_CMD);
    wire enable = ctrl[SSP_CTRL_ENABLE];
    wire slave = ctrl[SSP_CTRL_SLAVE];
    wire out_dis = ctrl[SSP_CTRL_OUT_DIS];
    wire master_en = enable && !slave;
    wire slave_en = enable && slave;

    // Frame layout in clock slots: optional frame-pulse slot, then sent bits; received bits share those slots except in command format, where they follow.
    wire [4:0] pre_slots = is_pulse ? 5'h01 : 5'h00;
    wire [4:0] out_slots = is_cmd ? SSP_CMD_BITS : size;
    wire [4:0] in_first = is_cmd ? pre_slots + SSP_CMD_BITS : pre_slots;
    wire [4:0] last_slot = in_first + size - 5'h01;

    function automatic logic slot_out(input logic [4:0] s, input logic [4:0] pre,
                                      input logic [4:0] n);
        slot_out = (s >= pre) && (s < pre + n);
    endfunction

    function automatic logic slot_in(input logic [4:0] s, input logic [4:0] first,
                                     input logic [4:0] last);
        slot_in = (s >= first) && (s <= last);
    endfunction

    // Pin inputs pass two flip-flops; clock and frame get a third stage so their edges can be found.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sclk_m1 <= 1'b0;
            sclk_m2 <= 1'b0;
            sclk_d <= 1'b0;
            fss_m1 <= 1'b1;
            fss_m2 <= 1'b1;
            fss_d <= 1'b1;
            rxd_m1 <= 1'b0;
            rxd_m2 <= 1'b0;
        end else begin
            sclk_m1 <= sclk_in;
            sclk_m2 <= sclk_m1;
            sclk_d <= sclk_m2;
            fss_m1 <= fss_in;
            fss_m2 <= fss_m1;
            fss_d <= fss_m2;
            rxd_m1 <= rxd_in;
            rxd_m2 <= rxd_m1;
        end
    end

    wire slv_rise = slave_en && sclk_m2 && !sclk_d;
    wire slv_fall = slave_en && !sclk_m2 && sclk_d;
    wire slv_fss_fall = slave_en && !fss_m2 && fss_d;
    wire slv_fss_rise = slave_en && fss_m2 && !fss_d;

    // Master bit clock: prescaler halves first, then the rate divider counts prescaler ticks.
    wire [6:0] pre_lim = (prescale[7:1] == 7'h00) ? 7'h00 : prescale[7:1] - 7'h01;
    wire pre_tick = (pre_cnt == pre_lim);
    wire half_tick = master_en && (state != SSP_IDLE) && pre_tick && (rate_cnt == rate);

    always_ff @(posedge sys_clk) begin
        if (reset || state == SSP_IDLE || !master_en) begin
            pre_cnt <= 7'h00;
            rate_cnt <= 8'h00;
        end else if (pre_tick) begin
            pre_cnt <= 7'h00;
            rate_cnt <= (rate_cnt == rate) ? 8'h00 : rate_cnt + 8'h01;
        end else begin
            pre_cnt <= pre_cnt + 7'h01;
        end
    end

    // Bus decode and FIFO hookup.
    wire wr_ctrl = bus_write && (bus_addr == SSP_ADDR_CTRL);
    wire wr_pre = bus_write && (bus_addr == SSP_ADDR_PRESCALE);
    wire wr_rate = bus_write && (bus_addr == SSP_ADDR_RATE);
    wire wr_data = bus_write && (bus_addr == SSP_ADDR_DATA);
    wire wr_stat = bus_write && (bus_addr == SSP_ADDR_STATUS);
    wire rd_data = bus_read && (bus_addr == SSP_ADDR_DATA);

    wire tx_in_ready;
    wire tx_valid;
    wire [15:0] tx_head;
    wire rx_in_ready;
    wire rx_valid;
    wire [15:0] rx_head;

    wire trail_ev = master_en ? half_tick : slv_rise;
    wire lead_ev = master_en ? half_tick : slv_fall;
    wire m_start = master_en && (state == SSP_IDLE) && tx_valid && rx_in_ready;
    wire s_start = (state == SSP_IDLE) && (is_pulse ? (slv_rise && fss_m2) : slv_fss_fall);
    wire start = m_start || s_start;
    wire tx_pop = start && tx_valid;
    wire s_abort = slave_en && !is_pulse && (state != SSP_IDLE) && slv_fss_rise;
    wire frame_end = (state == SSP_TRAIL) && lead_ev && (slot == last_slot);
    wire [4:0] start_slot = (slave_en && is_pulse) ? 5'h01 : 5'h00;

    ssp_fifo #(.WIDTH(SSP_DATA_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
        .sys_clk(sys_clk),
        .reset(reset),
        .in_valid(wr_data),
        .in_ready(tx_in_ready),
        .in_data(bus_wdata),
        .out_valid(tx_valid),
        .out_ready(tx_pop),
        .out_data(tx_head)
    );

    ssp_fifo #(.WIDTH(SSP_DATA_W), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
        .sys_clk(sys_clk),
        .reset(reset),
        .in_valid(rx_push),
        .in_ready(rx_in_ready),
        .in_data(rx_word),
        .out_valid(rx_valid),
        .out_ready(rd_data),
        .out_data(rx_head)
    );

    // Outgoing words are left aligned so the first bit sent is always bit 15.
    wire [15:0] tx_word = tx_valid ? tx_head : 16'h0000;
    wire [3:0] out_shift = is_cmd ? 4'h8 : 4'hF - size_m1;
    wire [15:0] tx_aligned = tx_word << out_shift;
    wire [15:0] shifted_tx = slot_out(slot, pre_slots, out_slots) ? {tx_sh[14:0], 1'b0} : tx_sh;
    wire [4:0] next_slot = slot + 5'h01;
    wire [15:0] size_mask = 16'hFFFF >> (4'hF - size_m1);
    wire fss_idle = !is_pulse;

    // Frame engine shared by master and slave; the event sources differ and only the master passes through SSP_GAP.
    always_ff @(posedge sys_clk) begin
        if (reset || !enable || s_abort) begin
            state <= SSP_IDLE;
            slot <= 5'h00;
            tx_sh <= 16'h0000;
            rx_sh <= 16'h0000;
        end else begin
            unique case (state)
                SSP_IDLE: begin
                    if (start) begin
                        state <= SSP_LEAD;
                        slot <= start_slot;
                        tx_sh <= tx_aligned;
                        rx_sh <= 16'h0000;
                    end
                end
                SSP_LEAD: begin
                    if (trail_ev) begin
                        state <= SSP_TRAIL;
                        if (slot_in(slot, in_first, last_slot)) begin
                            rx_sh <= {rx_sh[14:0], rxd_m2};
                        end
                    end
                end
                SSP_TRAIL: begin
                    if (frame_end) begin
                        state <= master_en ? SSP_GAP : SSP_IDLE;
                    end else if (lead_ev) begin
                        state <= SSP_LEAD;
                        slot <= next_slot;
                        tx_sh <= shifted_tx;
                    end
                end
                SSP_GAP: begin
                    if (half_tick) begin
                        state <= SSP_IDLE;
                    end
                end
            endcase
        end
    end

    // Received words and the overrun flag; a new overrun wins over a clear.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rx_push <= 1'b0;
            rx_word <= 16'h0000;
            overrun <= 1'b0;
        end else begin
            rx_push <= frame_end;
            rx_word <= rx_sh & size_mask;
            if (rx_push && !rx_in_ready) begin
                overrun <= 1'b1;
            end else if (wr_stat && bus_wdata[SSP_STAT_OVERRUN]) begin
                overrun <= 1'b0;
            end
        end
    end

    // Pin drivers, all registered.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sclk_out <= 1'b0;
            sclk_oe <= 1'b0;
            fss_out <= 1'b1;
            fss_oe <= 1'b0;
            txd_out <= 1'b0;
            txd_oe <= 1'b0;
        end else begin
            sclk_oe <= master_en;
            fss_oe <= master_en;
            txd_oe <= master_en || (slave_en && !out_dis && state != SSP_IDLE);
            if (state == SSP_IDLE && !start) begin
                sclk_out <= 1'b0;
                fss_out <= fss_idle;
                txd_out <= 1'b0;
            end else if (start) begin
                fss_out <= is_pulse;
                txd_out <= slot_out(start_slot, pre_slots, out_slots) && tx_aligned[15];
            end else if (frame_end || state == SSP_GAP) begin
                sclk_out <= 1'b0;
                fss_out <= fss_idle;
                txd_out <= 1'b0;
            end else if (state == SSP_LEAD && trail_ev) begin
                sclk_out <= 1'b1;
            end else if (state == SSP_TRAIL && lead_ev) begin
                sclk_out <= 1'b0;
                fss_out <= is_pulse ? 1'b0 : 1'b0;
                txd_out <= slot_out(next_slot, pre_slots, out_slots) && shifted_tx[15];
            end
        end
    end

    // Register writes.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ctrl <= SSP_CTRL_RST;
            prescale <= SSP_PRESCALE_RST;
            rate <= SSP_RATE_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl <= bus_wdata[8:0];
            end
            if (wr_pre) begin
                prescale <= bus_wdata[7:0];
            end
            if (wr_rate) begin
                rate <= bus_wdata[7:0];
            end
        end
    end

    // Read data stand in the cycle after the read strobe.
    wire [15:0] status = {10'h000, overrun, state != SSP_IDLE, !rx_in_ready, rx_valid,
                          tx_in_ready, !tx_valid};
    wire [15:0] rd_mux = (bus_addr == SSP_ADDR_CTRL) ? {7'h00, ctrl} :
                         (bus_addr == SSP_ADDR_PRESCALE) ? {8'h00, prescale} :
                         (bus_addr == SSP_ADDR_RATE) ? {8'h00, rate} :
                         (bus_addr == SSP_ADDR_DATA) ? (rx_valid ? rx_head : 16'h0000) :
                         (bus_addr == SSP_ADDR_STATUS) ? status : 16'h0000;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            bus_rdata <= 16'h0000;
        end else begin
            bus_rdata <= bus_read ? rd_mux : 16'h0000;
        end
    end

    // Helper: cycles since the last half tick, used to check the divided clock period.
    logic [15:0] tick_gap;
    always_ff @(posedge sys_clk) begin
        if (reset || half_tick || state == SSP_IDLE) begin
            tick_gap <= 16'h0000;
        end else begin
            tick_gap <= tick_gap + 16'h0001;
        end
    end
    wire [15:0] half_period = {9'h000, pre_lim + 7'h01} * ({8'h00, rate} + 16'h0001);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence seq_start;
        m_start && !is_pulse;
    endsequence

    sequence seq_end;
        frame_end && master_en;
    endsequence

    a_size_range: assert property (size >= 5'h04 && size <= 5'h10)
        else $error("frame size outside 4 to 16");
    a_frame_low: assert property (seq_start |=> !fss_out && sclk_out == 1'b0)
        else $error("frame not asserted after master start");
    a_frame_high: assert property (seq_end ##1 (!is_pulse && $stable(ctrl)) |-> fss_out)
        else $error("frame not released after last bit");
    a_start_needs: assert property (master_en && state == SSP_IDLE && !(tx_valid && rx_in_ready)
                                    |=> state == SSP_IDLE)
        else $error("master frame started without data or room");
    a_slave_quiet: assert property (slave_en && out_dis |=> !txd_oe)
        else $error("slave drives data while output disabled");
    a_slave_noclk: assert property (slave_en ##1 slave_en |-> !sclk_oe && !fss_oe)
        else $error("slave drives clock or frame");
    a_master_oe: assert property (master_en ##1 master_en |-> sclk_oe && fss_oe && txd_oe)
        else $error("master does not drive its pins");
    a_tick_period: assert property (half_tick && $stable(prescale) && $stable(rate)
                                     && $past(state) != SSP_IDLE |->
                                     tick_gap == half_period - 16'h0001)
        else $error("half period of serial clock wrong");
    a_overrun_set: assert property (rx_push && !rx_in_ready |=> overrun)
        else $error("lost word not flagged");
    a_push_follows: assert property (frame_end |=> rx_push)
        else $error("received word not pushed");
endmodule
`default_nettype wire

/* ssp_peer.sv */
`timescale 1ns/1ps
`default_nettype none
module ssp_peer (
    input wire logic sys_clk,
    input wire logic sclk,
    input wire logic mosi,
    output logic miso,
    output logic sclk_drv,
    output logic fss_drv
);
    logic [31:0] tx_sr = 32'h0000_0000;
    logic [31:0] rx_sr = 32'h0000_0000;
    logic last = 1'b0;
    logic flip = 1'b0;
    int rises = 0;
    int hi_cnt = 0;
    int lim = 0;
    // Past its last bit the peer lets go, so the line toggles rather than holding a value.
    assign miso = (rises < lim) ? tx_sr[31] : flip;
    initial begin
        sclk_drv = 1'b0;
        fss_drv = 1'b1;
    end
    always @(posedge sys_clk) begin
        last <= sclk;
        flip <= ~flip;
        if (sclk) begin
            hi_cnt <= hi_cnt + 1;
        end
        if (sclk && !last) begin
            rx_sr <= {rx_sr[30:0], mosi};
            rises <= rises + 1;
        end
        if (!sclk && last) begin
            tx_sr <= {tx_sr[30:0], tx_sr[31]};
        end
    end
    task automatic load(input logic [31:0] w, input int n);
        @(negedge sys_clk);
        tx_sr = w;
        rx_sr = 32'h0000_0000;
        rises = 0;
        hi_cnt = 0;
        lim = n;
    endtask
    // As link master the peer owns clock and frame; both stand still outside the frame.
    task automatic master_frame(input int n, input int half);
        fss_drv = 1'b0;
        repeat (half) @(negedge sys_clk);
        for (int i = 0; i < n; i++) begin
            repeat (half) @(negedge sys_clk);
            sclk_drv = 1'b1;
            repeat (half) @(negedge sys_clk);
            sclk_drv = 1'b0;
        end
        repeat (half) @(negedge sys_clk);
        fss_drv = 1'b1;
    endtask
endmodule
`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench
    import ssp_pkg::*;
;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] bus_addr = 8'h00;
    logic [15:0] bus_wdata = 16'h0000;
    logic bus_write = 1'b0;
    logic bus_read = 1'b0;
    logic flip = 1'b0;
    logic [15:0] bus_rdata;
    logic sclk_out, sclk_oe, fss_out, fss_oe, txd_out, txd_oe;
    logic miso, sclk_drv, fss_drv, sclk_pin, fss_pin, mosi;
    logic [7:0] ra [5] = '{SSP_ADDR_CTRL, SSP_ADDR_PRESCALE, SSP_ADDR_RATE, SSP_ADDR_STATUS, 8'h14};
    logic [15:0] rv [5] = '{16'h0007, 16'h0002, 16'h0000, 16'h0003, 16'h0000};
    int err_count = 0;
    int cmp_count = 0;
    int oe_cnt = 0;
    assign sclk_pin = sclk_oe ? sclk_out : sclk_drv;
    assign fss_pin = fss_oe ? fss_out : fss_drv;
    assign mosi = txd_oe ? txd_out : flip;
    always @(posedge sys_clk) begin
        flip <= ~flip;
        if (txd_oe) begin
            oe_cnt <= oe_cnt + 1;
        end
    end
    initial begin
        forever #10 sys_clk = ~sys_clk;
    end
    ssp_top i_dut (
        .sys_clk(sys_clk), .reset(reset), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
        .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata),
        .sclk_in(sclk_pin), .sclk_out(sclk_out), .sclk_oe(sclk_oe), .fss_in(fss_pin),
        .fss_out(fss_out), .fss_oe(fss_oe), .rxd_in(miso), .txd_out(txd_out), .txd_oe(txd_oe)
    );
    ssp_peer i_peer (
        .sys_clk(sys_clk), .sclk(sclk_pin), .mosi(mosi), .miso(miso),
        .sclk_drv(sclk_drv), .fss_drv(fss_drv)
    );
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        bus_addr <= a;
        bus_wdata <= d;
        bus_write <= 1'b1;
        @(posedge sys_clk);
        bus_write <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        bus_addr <= a;
        bus_read <= 1'b1;
        @(posedge sys_clk);
        bus_read <= 1'b0;
        #1 d = bus_rdata;
    endtask
    task automatic wait_rises(input int n);
        int i;
        for (i = 0; i < 20000; i++) begin
            if (i_peer.rises >= n) break;
            @(posedge sys_clk);
        end
        if (i == 20000) begin
            err_count++;
            wrap_up();
        end
    endtask
    task automatic wait_idle();
        logic [15:0] s;
        int i;
        for (i = 0; i < 200; i++) begin
            rd(SSP_ADDR_STATUS, s);
            if (s[4] === 1'b0) break;
        end
        if (i == 200) begin
            err_count++;
            wrap_up();
        end
    endtask
    initial begin
        logic [15:0] d;
        logic [31:0] w, e, m;
        logic [15:0] q [$];
        int sz, fmt, ps, rt, half, n, o;
        void'($urandom(32'hc6cea7f9));
        repeat (3) @(posedge sys_clk);
        reset <= 1'b0;
        #1 check("sclk_oe", 32'h0000_0000, 32'(sclk_oe));
        check("fss_out", 32'h0000_0001, 32'(fss_out));
        check("fss_oe", 32'h0000_0000, 32'(fss_oe));
        check("txd_oe", 32'h0000_0000, 32'(txd_oe));
        wr(8'h14, 16'hFFFF);
        foreach (ra[k]) begin
            rd(ra[k], d);
            check("register", 32'(rv[k]), 32'(d));
        end
        for (int i = 0; i < 13; i++) begin
            sz = i + 4;
            fmt = i % 4;
            ps = 4 + 4 * (i % 2);
            rt = 1 + i % 3;
            half = ps / 2 * (rt + 1);
            n = (fmt == 1) ? sz + 1 : (fmt == 2) ? sz + 8 : sz;
            m = (32'h0000_0001 << sz) - 1;
            w = $urandom;
            d = 16'($urandom & m);
            wr(SSP_ADDR_PRESCALE, 16'(ps));
            wr(SSP_ADDR_RATE, 16'(rt));
            wr(SSP_ADDR_CTRL, 16'(sz - 1 + fmt * 16 + 64));
            i_peer.load(w, n);
            wr(SSP_ADDR_DATA, d);
            wait_rises(n);
            wait_idle();
            check("sclk high cycles", 32'(n * half), 32'(i_peer.hi_cnt));
            check("fss idle", 32'(fmt != 1), 32'(fss_out));
            check("fss_oe master", 32'h0000_0001, 32'(fss_oe));
            e = (fmt == 2) ? (32'(d[7:0]) << sz) : 32'(d);
            check("peer rx", e, i_peer.rx_sr & ((32'h0000_0001 << n) - 1));
            rd(SSP_ADDR_DATA, d);
            check("rx word", (w >> (32 - n)) & m, 32'(d));
        end
        wr(SSP_ADDR_CTRL, 16'h0007);
        wr(SSP_ADDR_PRESCALE, 16'h0004);
        w = $urandom;
        i_peer.load(w, 1000);
        for (int i = 0; i < 9; i++) begin
            q.push_back(16'($urandom & 32'h0000_00FF));
            wr(SSP_ADDR_DATA, q[i]);
        end
        rd(SSP_ADDR_STATUS, d);
        check("status tx full", 32'h0000_0000, 32'(d));
        wr(SSP_ADDR_CTRL, 16'h0047);
        wait_rises(64);
        // The ninth word was dropped while TX was full; now it must wait for RX room.
        wr(SSP_ADDR_DATA, q[8]);
        repeat (200) @(posedge sys_clk);
        check("start while rx full", 32'h0000_0040, 32'(i_peer.rises));
        rd(SSP_ADDR_STATUS, d);
        check("status rx full", 32'h0000_000E, 32'(d));
        for (int k = 0; k < 9; k++) begin
            if (k == 8) begin
                wait_rises(72);
                wait_idle();
            end
            o = 8 * (k % 4);
            rd(SSP_ADDR_DATA, d);
            check("fifo rx", ((w << o) | (w >> (32 - o))) >> 24, 32'(d));
        end
        check("peer stream", {q[5][7:0], q[6][7:0], q[7][7:0], q[8][7:0]}, i_peer.rx_sr);
        rd(SSP_ADDR_DATA, d);
        check("empty rx read", 32'h0000_0000, 32'(d));
        for (int k = 0; k < 2; k++) begin
            wr(SSP_ADDR_CTRL, 16'(32'h0000_00CB | (k << 8)));
            d = 16'($urandom & 32'h0000_0FFF);
            wr(SSP_ADDR_DATA, d);
            w = $urandom;
            i_peer.load(w, 12);
            o = oe_cnt;
            i_peer.master_frame(12, 6);
            repeat (6) @(posedge sys_clk);
            wait_idle();
            check("slave txd_oe", 32'(k == 0), 32'(oe_cnt > o));
            if (k == 0) begin
                check("slave tx", 32'(d), i_peer.rx_sr & 32'h0000_0FFF);
            end
            rd(SSP_ADDR_DATA, d);
            check("slave rx", w >> 20, 32'(d));
        end
        // Nine slave frames into an empty RX FIFO: the ninth word is lost and flagged.
        wr(SSP_ADDR_CTRL, 16'h00C3);
        for (int k = 0; k < 9; k++) begin
            repeat (4) @(negedge sys_clk);
            i_peer.master_frame(4, 4);
        end
        repeat (4) @(negedge sys_clk);
        rd(SSP_ADDR_STATUS, d);
        check("status overrun", 32'h0000_002F, 32'(d));
        wr(SSP_ADDR_STATUS, 16'h0020);
        rd(SSP_ADDR_STATUS, d);
        check("overrun clear", 32'h0000_000F, 32'(d));
        wrap_up();
    end
endmodule
`default_nettype wire
